//--- core/dtso_bus_arb.sv
/*
  local bus arbiter for debug memory commands: stalls fetch, waits for idle, grants, reclaims.
  assumes the core reports bus idle and finishes a debug cycle with done.
*/
`timescale 1ns/100ps
module dtso_bus_arb (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // request side
  input  wire logic i_req,
  input  wire logic i_bus_idle,
  input  wire logic i_done,
  // outputs
  output logic      o_stall,
  output logic      o_grant
);
  import dtso_pkg::*;
  typedef enum logic [1:0] {DTSO_A_IDLE, DTSO_A_WAIT, DTSO_A_OWN} dtso_arb_type;
  typedef struct packed {
    dtso_arb_type st;
  } dtso_arbs_type;
  dtso_arbs_type s, next_s;
  always_comb begin
    next_s = s;
    unique case (s.st)
      DTSO_A_IDLE: if (i_req) next_s.st = DTSO_A_WAIT;
      DTSO_A_WAIT: if (i_bus_idle) next_s.st = DTSO_A_OWN;
      DTSO_A_OWN:  if (i_done) next_s.st = DTSO_A_IDLE;
      default:     next_s.st = DTSO_A_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '{st: DTSO_A_IDLE};
    end else begin
      s <= next_s;
    end
  end
  assign o_stall = s.st != DTSO_A_IDLE;
  assign o_grant = s.st == DTSO_A_OWN;
  chk_grant_stalls: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_grant |-> o_stall) else $error("grant without fetch stall");
  chk_wait_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($rose(o_grant)) |-> $past(i_bus_idle)) else $error("grant before bus idle");
endmodule

//--- core/dtso_serial.sv
/*
  serialiser: sends a marker then the captured bytes as nibbles, least significant first.
  assumes the source holds valid only while busy is low.
*/
`timescale 1ns/100ps
module dtso_serial (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rstn,
  // item in
  dtso_item_if.dst    item,
  // nibble out
  output logic        o_act,
  output logic [3:0]  o_nib
);
  import dtso_pkg::*;
  typedef struct packed {
    logic        act;
    logic [3:0]  nib;
    logic [31:0] sh;
    logic [3:0]  left;
  } dtso_ser_type;
  dtso_ser_type s, next_s;
  assign item.busy = s.left != 4'h0;
  assign o_act = s.act;
  assign o_nib = s.nib;
  always_comb begin
    next_s = s;
    next_s.act = 1'b0;
    if (s.left != 4'h0) begin
      next_s.act = 1'b1;
      next_s.nib = s.sh[3:0];
      next_s.sh = {4'h0, s.sh[31:4]};
      next_s.left = s.left - 4'h1;
    end else if (item.valid) begin
      next_s.act = 1'b1;
      next_s.nib = item.marker;
      next_s.sh = item.data;
      next_s.left = item.nibs;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  chk_nib_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (item.valid && !item.busy && item.nibs == 4'h2) |=> o_act [*3]) else $error("byte not sent in two nibbles");
endmodule

//--- core/dtso_trace.sv
/*
  trace status and debug data output sequencer with debug register port and bus arbitration.
  assumes the core pushes one retire event per cycle only while o_CORE_READY is high, and
  reports each memory operand with its kind (source or destination) and size.
*/
`timescale 1ns/100ps
module dtso_trace (
  // clock and reset
  input  wire logic                    I_CLK,
  input  wire logic                    I_RSTN,
  // core retire events
  input  wire logic                    I_EV_VALID,
  input  wire dtso_pkg::dtso_event_type I_EV_KIND,
  input  wire logic                    I_EV_TAKEN,
  // core operand capture
  input  wire logic                    I_OP_VALID,
  input  wire logic                    I_OP_IS_WR,
  input  wire logic                    I_OP_IS_MEM,
  input  wire logic                    I_OP_BURST,
  input  wire dtso_pkg::dtso_size_type I_OP_SIZE,
  input  wire logic [31:0]             I_OP_DATA,
  input  wire logic                    I_OP_RESET_FETCH,
  // core target address
  input  wire logic                    I_TGT_VALID,
  input  wire dtso_pkg::dtso_size_type I_TGT_SIZE,
  input  wire logic [31:0]             I_TGT_ADDR,
  // debug register port
  input  wire logic [3:0]              I_ADDR,
  input  wire logic [31:0]             I_WDATA,
  input  wire logic                    I_WR,
  input  wire logic                    I_RD,
  input  wire logic                    I_CPU_REG_CMD,
  output logic [31:0]                  O_RDATA,
  // local bus arbitration
  input  wire logic                    I_BUS_IDLE,
  input  wire logic                    I_BUS_DONE,
  input  wire logic [31:0]             I_BUS_RDATA,
  output logic                         O_FETCH_STALL,
  output logic                         O_BUS_GRANT,
  output logic                         O_BUS_WR,
  output logic [31:0]                  O_BUS_ADDR,
  output logic [31:0]                  O_BUS_WDATA,
  // trace
  output logic [3:0]                   O_TRACE,
  output logic                         O_CORE_READY
);
  import dtso_pkg::*;
  typedef struct packed {
    logic [31:0]  cfg;
    logic         exc;
    logic         exc_done;
    logic [3:0]   pend;
    logic         pend_v;
    logic         tail_taken;
    logic [31:0]  rdata;
    logic         rej;
    logic         mreq;
    logic         mwr;
    logic [31:0]  maddr;
    logic [31:0]  mdata;
    logic [3:0]   trace;
  } dtso_state_type;
  dtso_state_type s, next_s;
  dtso_item_if item ();
  logic       ser_act;
  logic [3:0] ser_nib;
  logic       arb_stall;
  logic       arb_grant;
  logic       op_show;
  logic       tgt_show;
  logic       ev_ok;

  function automatic logic [3:0] op_marker(input dtso_size_type sz);
    unique case (sz)
      DTSO_SZ_B: op_marker = MK_1B;
      DTSO_SZ_W: op_marker = MK_2B;
      DTSO_SZ_3: op_marker = MK_3B;
      DTSO_SZ_L: op_marker = MK_4B;
    endcase
  endfunction
  function automatic logic [3:0] nib_count(input dtso_size_type sz);
    // four bits wide so that a long's eight nibbles fit
    nib_count = 4'({sz, 1'b0}) + 4'h2;
  endfunction

  dtso_serial u_serial (
    .i_clk  (I_CLK),
    .i_rstn (I_RSTN),
    .item   (item.dst),
    .o_act  (ser_act),
    .o_nib  (ser_nib)
  );
  dtso_bus_arb u_arb (
    .i_clk      (I_CLK),
    .i_rstn     (I_RSTN),
    .i_req      (s.mreq),
    .i_bus_idle (I_BUS_IDLE),
    .i_done     (I_BUS_DONE),
    .o_stall    (arb_stall),
    .o_grant    (arb_grant)
  );

  // operand capture: memory only, never bursts or reset vector fetches, per read/write enable
  assign op_show = I_OP_VALID && I_OP_IS_MEM && !I_OP_BURST && !I_OP_RESET_FETCH &&
                   (I_OP_IS_WR ? s.cfg[CFG_WR_POS] : s.cfg[CFG_RD_POS]);
  assign tgt_show = I_TGT_VALID && s.cfg[CFG_BTB_POS];
  // an item and a status code may not share a cycle: the port is one nibble wide
  assign ev_ok = !item.busy && !s.pend_v;
  assign item.valid  = !item.busy && (op_show || tgt_show);
  // operand wins when both arrive; the core offers them in separate cycles
  assign item.marker = op_show ? op_marker(I_OP_SIZE) : op_marker(I_TGT_SIZE);
  assign item.data   = op_show ? I_OP_DATA : I_TGT_ADDR;
  assign item.nibs   = op_show ? nib_count(I_OP_SIZE) : nib_count(I_TGT_SIZE);

  always_comb begin
    next_s = s;
    next_s.rdata = s.rdata;
    next_s.rej = 1'b0;
    next_s.pend_v = s.pend_v;
    // status code path: a code queued while the serialiser runs waits in pend
    // taken only while ready, so a code never lands under a running serialiser
    if (I_EV_VALID && ev_ok) begin
      next_s.pend_v = 1'b1;
      unique case (I_EV_KIND)
        DTSO_EV_NONE:    next_s.pend_v = 1'b0;
        DTSO_EV_PLAIN:   next_s.pend = ST_DONE;
        DTSO_EV_BCC:     next_s.pend = I_EV_TAKEN ? ST_TAKEN : ST_DONE;
        DTSO_EV_BRA:     next_s.pend = ST_TAKEN;
        DTSO_EV_BSR:     next_s.pend = ST_TAKEN;
        DTSO_EV_JMP:     next_s.pend = ST_TAKEN;
        DTSO_EV_JSR:     next_s.pend = ST_TAKEN;
        DTSO_EV_RTS: begin
          next_s.pend = ST_DONE;
          next_s.tail_taken = 1'b1;
        end
        DTSO_EV_PULSE:   next_s.pend = ST_PULSE;
        DTSO_EV_WDDATA:  next_s.pend = ST_PULSE;
        DTSO_EV_EXC, DTSO_EV_RESET: begin
          next_s.pend = ST_EXC;
          next_s.exc = 1'b1;
        end
        DTSO_EV_EMU_IN:  next_s.pend = ST_EMU_IN;
        DTSO_EV_EMU_OUT: next_s.pend = ST_EMU_EXIT;
        default:         next_s.pend_v = 1'b0;
      endcase
    end else if (!item.busy && !ser_act && !item.valid && s.pend_v) begin
      next_s.pend_v = s.tail_taken;
      next_s.pend = ST_TAKEN;
      next_s.tail_taken = 1'b0;
    end
    // exception state ends with the handler's taken-branch code
    if (s.exc && s.pend_v && s.pend == ST_TAKEN && !item.busy && !ser_act && !item.valid) begin
      next_s.exc = 1'b0;
    end
    if (s.pend_v && s.pend == ST_EXC && !item.busy && !ser_act && !item.valid && !s.tail_taken) begin
      next_s.pend_v = 1'b0;
    end
    // output mux: serialiser first, then a pending code, else 0xC in exceptions
    if (ser_act) begin
      next_s.trace = ser_nib;
    end else if (s.pend_v && !item.valid) begin
      next_s.trace = s.pend;
    end else begin
      next_s.trace = s.exc ? ST_EXC : ST_IDLE;
    end
    // bus answer first, so a command written in the same cycle wins
    if (arb_grant && I_BUS_DONE) begin
      next_s.mreq = 1'b0;
      if (!s.mwr) begin
        next_s.mdata = I_BUS_RDATA;
      end
    end
    // register port; core register commands are always refused
    if (I_WR) begin
      unique case (I_ADDR)
        REG_CFG:   next_s.cfg = I_WDATA;
        REG_MADDR: begin
          next_s.maddr = I_WDATA;
          next_s.mwr = I_WDATA[MCMD_WR_POS];
          next_s.mreq = 1'b1;
        end
        REG_MDATA: next_s.mdata = I_WDATA;
        default: ;
      endcase
    end
    if (I_CPU_REG_CMD) begin
      next_s.rej = 1'b1;
    end
    next_s.rdata = 32'h0000_0000;
    if (I_RD) begin
      unique case (I_ADDR)
        REG_CFG:   next_s.rdata = s.cfg;
        REG_STAT:  next_s.rdata = {28'h0000000, s.rej, s.exc, arb_grant, s.mreq};
        REG_MADDR: next_s.rdata = s.maddr;
        REG_MDATA: next_s.rdata = s.mdata;
        default:   next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s <= '0;
      s.cfg <= CFG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign O_TRACE       = s.trace;
  assign O_RDATA       = s.rdata;
  assign O_FETCH_STALL = arb_stall;
  assign O_BUS_GRANT   = arb_grant;
  assign O_BUS_WR      = s.mwr;
  assign O_BUS_ADDR    = s.maddr;
  assign O_BUS_WDATA   = s.mdata;
  assign O_CORE_READY  = ev_ok;

  chk_plain_done: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_EV_VALID && ev_ok && I_EV_KIND == DTSO_EV_PLAIN && !op_show && !tgt_show && !ser_act)
    |=> ##1 O_TRACE == ST_DONE) else $error("completion code missing");
  chk_bcc_taken: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_EV_VALID && ev_ok && I_EV_KIND == DTSO_EV_BCC && I_EV_TAKEN && !op_show && !tgt_show && !ser_act)
    |=> ##1 O_TRACE == ST_TAKEN) else $error("taken branch code missing");
  chk_rts_tail: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_EV_VALID && ev_ok && I_EV_KIND == DTSO_EV_RTS && !op_show && !tgt_show && !ser_act)
    |=> (!item.valid ##1 !item.valid) |=> O_TRACE == ST_TAKEN) else $error("return taken code missing");
  chk_pulse_code: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_EV_VALID && ev_ok && (I_EV_KIND == DTSO_EV_PULSE || I_EV_KIND == DTSO_EV_WDDATA) && !op_show && !tgt_show)
    |=> ##1 O_TRACE == ST_PULSE) else $error("pulse code missing");
  chk_emu_entry: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_EV_VALID && ev_ok && I_EV_KIND == DTSO_EV_EMU_IN && !op_show && !tgt_show)
    |=> ##1 O_TRACE == ST_EMU_IN) else $error("emulator entry code missing");
  chk_marker_size: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (item.valid && op_show && I_OP_SIZE == DTSO_SZ_W) |=> ##1 O_TRACE == MK_2B) else $error("wrong word marker");
  chk_no_reg_op: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_OP_VALID && !I_OP_IS_MEM && !tgt_show) |-> !item.valid) else $error("register operand captured");
  chk_no_burst: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_OP_BURST && !tgt_show) |-> !item.valid) else $error("burst operand captured");
  chk_reset_fetch: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_OP_RESET_FETCH && !tgt_show) |-> !item.valid) else $error("reset vector fetch captured");
  chk_btb_gate: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_TGT_VALID && !s.cfg[CFG_BTB_POS] && !op_show) |-> !item.valid) else $error("target shown while disabled");
  chk_exc_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (s.exc && !ser_act && !s.pend_v && !item.valid && !(I_EV_VALID && ev_ok))
    |=> ##1 O_TRACE == ST_EXC) else $error("exception code dropped");
  chk_exc_entry: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_EV_VALID && ev_ok && I_EV_KIND == DTSO_EV_EXC) |=> s.exc) else $error("exception state not entered");
  chk_exc_exit: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (s.exc && s.pend_v && s.pend == ST_TAKEN && !ser_act && !item.valid)
    |=> (!s.exc && O_TRACE == ST_TAKEN)) else $error("handler code did not end exception");
  chk_mem_req: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (I_WR && I_ADDR == REG_MADDR) |=> s.mreq) else $error("memory command not requested");
  chk_reg_reject: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_CPU_REG_CMD |=> s.rej) else $error("core register command not refused");
  cov_taken: cover property (@(posedge I_CLK) O_TRACE == ST_TAKEN);
  cov_exc: cover property (@(posedge I_CLK) O_TRACE == ST_EXC);
  cov_marker: cover property (@(posedge I_CLK) O_TRACE == MK_4B);
  cov_grant: cover property (@(posedge I_CLK) $rose(O_BUS_GRANT));
endmodule

//--- dv/dtso_emu_model.sv
/*
  local bus model seen by the debug unit: stays busy a set number of cycles after a fetch stall,
  then answers a granted debug cycle with one done pulse.
  assumes grant is held until done has been seen.
*/
`timescale 1ns/100ps
module dtso_emu_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // from the block
  input  wire logic        i_stall,
  input  wire logic        i_grant,
  input  wire logic [31:0] i_addr,
  input  wire logic [7:0]  i_busy_cycles,
  // bus answers
  output logic             o_idle,
  output logic             o_done,
  output logic [31:0]      o_rdata
);
  logic [7:0] cnt;
  logic       served;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= 8'h00;
      served <= 1'b0;
      o_idle <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else if (!i_stall) begin
      cnt <= 8'h00;
      served <= 1'b0;
      o_idle <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (!i_grant) begin
      // current activity drains before the bus is freed
      if (cnt == i_busy_cycles) begin
        o_idle <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
      end
      o_rdata <= ~o_rdata;
    end else begin
      // one debug cycle per grant, answered once
      o_done <= !served;
      served <= 1'b1;
      o_rdata <= served ? ~o_rdata : (i_addr ^ 32'hA5A5_0F0F);
    end
  end
endmodule

//--- dv/dtso_trace_tb.sv
/*
  self-checking bench for the trace status output block: events, operands, targets, registers,
  bus arbitration and exceptions.
  assumes codes and markers show on the trace one cycle after the edge that takes them.
*/
`timescale 1ns/100ps
module dtso_trace_tb;
  import dtso_pkg::*;
  logic           clk = 1'b0, rstn = 1'b0;
  logic           ev_valid = 1'b0, ev_taken = 1'b0, op_valid = 1'b0, op_wr = 1'b0, op_mem = 1'b0;
  logic           op_burst = 1'b0, op_rfetch = 1'b0, tgt_valid = 1'b0, wr = 1'b0, rd = 1'b0, cpu_cmd = 1'b0;
  dtso_event_type ev_kind = DTSO_EV_NONE;
  dtso_size_type  op_size = DTSO_SZ_B, tgt_size = DTSO_SZ_B;
  logic [31:0]    op_data = 32'h0, tgt_addr = 32'h0, wdata = 32'h0, seed = 32'd76474;
  logic [3:0]     addr = 4'h0;
  logic [7:0]     busy_cycles = 8'h00;
  logic [2:0]     cfg = 3'h0;
  logic [31:0]    rdata, bus_rdata, bus_addr, bus_wdata;
  logic [3:0]     trace;
  logic           bus_idle, bus_done, stall, grant, bus_wr, ready;
  int             fails = 0, checks = 0, cyc = 0;
  dtso_event_type kt[12] = '{DTSO_EV_PLAIN, DTSO_EV_BCC, DTSO_EV_BCC, DTSO_EV_BRA, DTSO_EV_BSR, DTSO_EV_JMP,
    DTSO_EV_JSR, DTSO_EV_RTS, DTSO_EV_PULSE, DTSO_EV_WDDATA, DTSO_EV_EMU_IN, DTSO_EV_EMU_OUT};
  logic           tt[12] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  logic [3:0]     c1t[12] = '{ST_DONE, ST_TAKEN, ST_DONE, ST_TAKEN, ST_TAKEN, ST_TAKEN, ST_TAKEN, ST_DONE,
    ST_PULSE, ST_PULSE, ST_EMU_IN, ST_EMU_EXIT};
  always #4 clk = ~clk;
  dtso_trace dut (.I_CLK(clk), .I_RSTN(rstn), .I_EV_VALID(ev_valid), .I_EV_KIND(ev_kind), .I_EV_TAKEN(ev_taken),
    .I_OP_VALID(op_valid), .I_OP_IS_WR(op_wr), .I_OP_IS_MEM(op_mem), .I_OP_BURST(op_burst), .I_OP_SIZE(op_size),
    .I_OP_DATA(op_data), .I_OP_RESET_FETCH(op_rfetch), .I_TGT_VALID(tgt_valid), .I_TGT_SIZE(tgt_size),
    .I_TGT_ADDR(tgt_addr), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_CPU_REG_CMD(cpu_cmd),
    .O_RDATA(rdata), .I_BUS_IDLE(bus_idle), .I_BUS_DONE(bus_done), .I_BUS_RDATA(bus_rdata),
    .O_FETCH_STALL(stall), .O_BUS_GRANT(grant), .O_BUS_WR(bus_wr), .O_BUS_ADDR(bus_addr),
    .O_BUS_WDATA(bus_wdata), .O_TRACE(trace), .O_CORE_READY(ready));
  dtso_emu_model partner (.i_clk(clk), .i_rstn(rstn), .i_stall(stall), .i_grant(grant), .i_addr(bus_addr),
    .i_busy_cycles(busy_cycles), .o_idle(bus_idle), .o_done(bus_done), .o_rdata(bus_rdata));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] mk(input dtso_size_type s);
    return (s == DTSO_SZ_B) ? MK_1B : (s == DTSO_SZ_W) ? MK_2B : (s == DTSO_SZ_3) ? MK_3B : MK_4B;
  endfunction
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access at a time, so nothing overlaps a core-side register write
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e, input string w);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(w, rdata, e);
  endtask
  // display settings change only between instructions
  task automatic wcfg(input logic [2:0] v);
    cfg = v;
    wreg(REG_CFG, {29'h0, v});
  endtask
  task automatic ev(input dtso_event_type k, input logic t, input logic [3:0] c1, input logic [3:0] c2);
    @(posedge clk);
    ev_kind <= k;
    ev_taken <= t;
    ev_valid <= 1'b1;
    @(negedge clk);
    while (ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    ev_valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("status code", trace, c1);
    if (c2 != ST_IDLE) begin
      @(negedge clk);
      chk("second code", trace, c2);
    end
  endtask
  // marker, then the bytes low nibble first, then the background code
  task automatic ser(input logic sh, input logic [3:0] m, input int n, input logic [31:0] d, input logic [3:0] bg);
    @(posedge clk);
    @(negedge clk);
    if (sh) begin
      chk("marker", trace, m);
      for (int i = 0; i < n; i++) begin
        @(negedge clk);
        chk("nibble", trace, d[4*i+:4]);
      end
      @(negedge clk);
    end
    chk("background", trace, bg);
  endtask
  task automatic op(input logic w, input logic m, input logic b, input dtso_size_type s, input logic [31:0] d,
                    input logic [3:0] bg);
    @(posedge clk);
    op_wr <= w;
    op_mem <= m;
    op_burst <= b;
    op_size <= s;
    op_data <= d;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    ser(m && !b && !op_rfetch && (w ? cfg[CFG_WR_POS] : cfg[CFG_RD_POS]), mk(s), 2 * (int'(s) + 1), d, bg);
  endtask
  task automatic tgt(input dtso_size_type s, input logic [31:0] a);
    @(posedge clk);
    tgt_size <= s;
    tgt_addr <= a;
    tgt_valid <= 1'b1;
    @(posedge clk);
    tgt_valid <= 1'b0;
    ser(cfg[CFG_BTB_POS], mk(s), 2 * (int'(s) + 1), a, ST_IDLE);
  endtask
  task automatic mcmd(input logic [31:0] a, input logic w, input logic [7:0] bc, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    busy_cycles <= bc;
    wreg(REG_MADDR, a | {31'h0, w});
    while (grant !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("stall at grant", stall, 1'b1);
    chk("grant waits idle", n >= int'(bc), 1'b1);
    chk("bus direction", bus_wr, w);
    if (w) chk("bus write data", bus_wdata, d);
    else chk("bus address", bus_addr, a);
    while (grant === 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    chk("bus reclaimed", stall, 1'b0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rreg(REG_CFG, CFG_RESET, "config reset");
    rreg(4'h2, 32'h0, "unmapped read");
    ev(DTSO_EV_PLAIN, 1'b0, ST_DONE, ST_IDLE);
    op(1'b0, 1'b1, 1'b0, DTSO_SZ_W, 32'h0000_5A3C, ST_IDLE);
    $display("test reset done");
    wcfg(3'h3);
    for (int i = 0; i < 12; i++) ev(kt[i], tt[i], c1t[i], (kt[i] == DTSO_EV_RTS) ? ST_TAKEN : ST_IDLE);
    ev(DTSO_EV_BSR, 1'b0, ST_TAKEN, ST_IDLE);
    op(1'b1, 1'b1, 1'b0, DTSO_SZ_L, 32'h1234_5678, ST_IDLE);
    ev(DTSO_EV_WDDATA, 1'b0, ST_PULSE, ST_IDLE);
    op(1'b0, 1'b1, 1'b0, DTSO_SZ_B, 32'h0000_00E7, ST_IDLE);
    ev(DTSO_EV_PLAIN, 1'b0, ST_DONE, ST_IDLE);
    op(1'b1, 1'b1, 1'b0, DTSO_SZ_L, 32'h0F1E_2D3C, ST_IDLE);
    op(1'b1, 1'b1, 1'b1, DTSO_SZ_L, 32'h4B5A_6978, ST_IDLE);
    op(1'b0, 1'b0, 1'b0, DTSO_SZ_L, 32'h8796_A5B4, ST_IDLE);
    ev(DTSO_EV_PLAIN, 1'b0, ST_DONE, ST_IDLE);
    op(1'b0, 1'b1, 1'b0, DTSO_SZ_B, 32'h0000_0081, ST_IDLE);
    op(1'b1, 1'b1, 1'b0, DTSO_SZ_W, 32'h0000_3C96, ST_IDLE);
    $display("test codes done");
    for (int i = 0; i < 24; i++) begin
      seed = nxt(seed);
      wcfg(seed[2:0]);
      ev(DTSO_EV_PLAIN, 1'b0, ST_DONE, ST_IDLE);
      seed = nxt(seed);
      op(seed[4], seed[5], seed[6] & seed[7], (seed[1:0] == 2'h2) ? DTSO_SZ_L : dtso_size_type'(seed[1:0]),
         nxt(seed), ST_IDLE);
    end
    $display("test random operands done");
    for (int b = 0; b < 2; b++) begin
      wcfg({b[0], 2'h0});
      ev(DTSO_EV_JMP, 1'b0, ST_TAKEN, ST_IDLE);
      tgt(DTSO_SZ_W, 32'h0000_BEEF);
      tgt(DTSO_SZ_3, 32'h0012_3456);
      tgt(DTSO_SZ_L, 32'h89AB_CDEF);
    end
    $display("test targets done");
    @(posedge clk);
    cpu_cmd <= 1'b1;
    @(posedge clk);
    // refused flag stands one cycle only, so the read goes out beside the dropped command
    cpu_cmd <= 1'b0;
    addr <= REG_STAT;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("refused status", rdata, 32'h0000_0008);
    rreg(REG_STAT, 32'h0000_0000, "refused flag gone");
    wreg(REG_MDATA, 32'hC3D2_E1F0);
    mcmd(32'h0000_4000, 1'b1, 8'h05, 32'hC3D2_E1F0);
    mcmd(32'h0000_8010, 1'b0, 8'h00, 32'h0);
    rreg(REG_MDATA, 32'h0000_8010 ^ 32'hA5A5_0F0F, "bus read data");
    $display("test bus done");
    wcfg(3'h3);
    ev(DTSO_EV_EXC, 1'b0, ST_EXC, ST_IDLE);
    repeat (3) begin
      @(negedge clk);
      chk("exception hold", trace, ST_EXC);
    end
    op(1'b1, 1'b1, 1'b0, DTSO_SZ_L, 32'h0000_2004, ST_EXC);
    op(1'b1, 1'b1, 1'b0, DTSO_SZ_L, 32'h4000_0000, ST_EXC);
    op(1'b0, 1'b1, 1'b0, DTSO_SZ_L, 32'h0000_0100, ST_EXC);
    ev(DTSO_EV_BRA, 1'b0, ST_TAKEN, ST_IDLE);
    $display("test exception done");
    @(posedge clk);
    rstn <= 1'b0;
    cfg = 3'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("trace in reset", trace, ST_IDLE);
    @(posedge clk);
    rstn <= 1'b1;
    rreg(REG_CFG, CFG_RESET, "config after reset");
    wcfg(3'h3);
    ev(DTSO_EV_RESET, 1'b0, ST_EXC, ST_IDLE);
    @(posedge clk);
    op_rfetch <= 1'b1;
    op(1'b0, 1'b1, 1'b0, DTSO_SZ_L, 32'h0000_0000, ST_EXC);
    op(1'b0, 1'b1, 1'b0, DTSO_SZ_L, 32'h0000_0004, ST_EXC);
    ev(DTSO_EV_JMP, 1'b0, ST_TAKEN, ST_IDLE);
    $display("test reset exception done");
    end_sim();
  end
endmodule

//--- pkg/dtso_item_if.sv
/*
  carries one queued trace item (marker plus bytes) between the sequencer and the serialiser.
  assumes both ends on I_CLK.
*/
`timescale 1ns/100ps
interface dtso_item_if;
  logic        valid;
  logic [3:0]  marker;
  logic [31:0] data;
  logic [3:0]  nibs;
  logic        busy;
  modport src (output valid, output marker, output data, output nibs, input busy);
  modport dst (input valid, input marker, input data, input nibs, output busy);
endinterface

//--- pkg/dtso_pkg.sv
/*
  trace status output package: status codes, markers, config bits, register map, event kinds.
  assumes a 4-bit trace port and a 32-bit debug register port.
*/
package dtso_pkg;
  // trace status codes
  localparam logic [3:0] ST_IDLE     = 4'h0;
  localparam logic [3:0] ST_DONE     = 4'h1;
  localparam logic [3:0] ST_PULSE    = 4'h4;
  localparam logic [3:0] ST_TAKEN    = 4'h5;
  localparam logic [3:0] ST_EMU_EXIT = 4'h7;
  localparam logic [3:0] MK_1B       = 4'h8;
  localparam logic [3:0] MK_2B       = 4'h9;
  localparam logic [3:0] MK_3B       = 4'hA;
  localparam logic [3:0] MK_4B       = 4'hB;
  localparam logic [3:0] ST_EXC      = 4'hC;
  localparam logic [3:0] ST_EMU_IN   = 4'hD;
  // register port
  localparam logic [3:0]  REG_CFG      = 4'h0;
  localparam logic [3:0]  REG_STAT     = 4'h4;
  localparam logic [3:0]  REG_MADDR    = 4'h8;
  localparam logic [3:0]  REG_MDATA    = 4'hC;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  // config field positions
  localparam int CFG_RD_POS  = 0;
  localparam int CFG_WR_POS  = 1;
  localparam int CFG_BTB_POS = 2;
  // memory command field positions in data word of MADDR write
  localparam int MCMD_WR_POS = 0;
  // operand size codes
  typedef enum logic [1:0] {DTSO_SZ_B, DTSO_SZ_W, DTSO_SZ_3, DTSO_SZ_L} dtso_size_type;
  // retire event kinds from the core
  typedef enum logic [3:0] {
    DTSO_EV_NONE, DTSO_EV_PLAIN, DTSO_EV_BCC, DTSO_EV_BRA, DTSO_EV_BSR, DTSO_EV_JMP,
    DTSO_EV_JSR, DTSO_EV_RTS, DTSO_EV_PULSE, DTSO_EV_WDDATA, DTSO_EV_EXC, DTSO_EV_RESET,
    DTSO_EV_EMU_IN, DTSO_EV_EMU_OUT
  } dtso_event_type;
  localparam int NIB_MAX = 8;
  localparam int ITEM_MAX = 4;
endpackage
